// ### pkg/tap_regs.vh
// tap_regs.vh: register offsets, field positions and reset values
// assumes: included by the tap event logic, no processes here
`ifndef TAP_REGS_VH
`define TAP_REGS_VH

`define TAP_CONFIG_ADDR      8'h21
`define TAP_SOURCE_ADDR      8'h22
`define TAP_THRESHOLD_X_ADDR 8'h23
`define TAP_THRESHOLD_Y_ADDR 8'h24
`define TAP_THRESHOLD_Z_ADDR 8'h25
`define TAP_TIME_LIMIT_ADDR  8'h26
`define TAP_LATENCY_ADDR     8'h27

`define CFG_ABORT_BIT        7
`define CFG_LATCH_BIT        6
`define SRC_ACTIVE_BIT       7
`define SRC_DOUBLE_BIT       3

`define CONFIG_RESET         8'h00
`define SOURCE_RESET         8'h00
`define THRESHOLD_RESET      7'h00
`define COUNT_RESET          8'h00

`endif

// ### rtl/tap_event_regs.v
// tap_event_regs.v: tap detection registers, one detector shared by all axes, source flags
// assumes: a serial register front end gives one-cycle read/write strobes
// with an 8-bit address on clk; sample_en pulses once per output data sample
// and accel_* are signed samples on clk, scaled 0.0156 g per lsb over 8 g
`timescale 1ns/1ps
`include "tap_regs.vh"

module tap_event_regs #(
  parameter DATA_W = 10
) (
  input  wire              clk,
  input  wire              rst_n,
  input  wire              sample_en,
  input  wire [DATA_W-1:0] accel_x,
  input  wire [DATA_W-1:0] accel_y,
  input  wire [DATA_W-1:0] accel_z,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  output reg               tap_irq
);

  // =========================================================
  // state encodings
  // idle:  waiting for any axis to rise above its threshold
  // above: a pulse is in progress; it must fall back inside the time
  //        limit to count as a tap, or it is dropped
  // lat:   latency after a tap; further pulses are not taps, but with
  //        abort set a short pulse here cancels the pending double
  // a tap that starts on the first sample after latency while a first
  // tap is pending is the second half of a double tap; any other tap
  // is a single
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ABOVE = 3'b010;
  localparam [2:0] ST_LAT   = 3'b100;

  // register file
  reg  [7:0]  config_q;
  reg  [6:0]  thr_x_q;
  reg  [6:0]  thr_y_q;
  reg  [6:0]  thr_z_q;
  reg  [7:0]  time_limit_q;
  reg  [7:0]  latency_q;
  // source flags
  reg  [7:0]  source_q;
  reg  [7:0]  source_d;
  // detector state and counters
  reg  [2:0]  state_q;
  reg  [7:0]  width_cnt_q;
  reg  [7:0]  lat_cnt_q;
  reg  [2:0]  axis_q;
  reg  [2:0]  pol_q;
  reg         first_seen_q;
  reg         single_pend_q;
  reg         lat_over_q;    // a pulse started inside the latency time
  // one-cycle event pulse towards the source register
  reg         ev_single;
  reg         ev_double;
  reg  [2:0]  ev_axis;
  reg  [2:0]  ev_pol;

  wire        abort_en  = config_q[`CFG_ABORT_BIT];
  wire        latch_en  = config_q[`CFG_LATCH_BIT];
  wire [2:0]  dbl_en    = {config_q[5], config_q[3], config_q[1]};
  wire [2:0]  sgl_en    = {config_q[4], config_q[2], config_q[0]};
  wire        src_rd    = reg_rd && (reg_addr == `TAP_SOURCE_ADDR);

  // =========================================================
  // magnitude of a signed sample, saturated to the 7-bit threshold scale
  function [7:0] mag7;
    input [DATA_W-1:0] v;
    reg   [DATA_W-1:0] a;
    begin
      a = v[DATA_W-1] ? (~v + {{(DATA_W-1){1'b0}}, 1'b1}) : v;
      // top bits map the full 8 g range onto 0.063 g steps
      // the most negative sample has no positive twin: saturate it
      mag7 = a[DATA_W-1] ? 8'h7f : {1'b0, a[DATA_W-2 -: 7]};
    end
  endfunction

  // =========================================================
  // axes of an event that the configuration lets through; a single tap
  // uses the single enables, a double tap the double enables
  function [2:0] qual_axes;
    input       is_double;
    input [2:0] axes;
    input [2:0] single_mask;
    input [2:0] double_mask;
    begin
      if (is_double)
        qual_axes = axes & double_mask;
      else
        qual_axes = axes & single_mask;
    end
  endfunction

  // =========================================================
  // a sample counter has reached its programmed limit
  function cnt_done;
    input [7:0] cnt;
    input [7:0] limit;
    begin
      cnt_done = (cnt >= limit);
    end
  endfunction

  // next value of a sample counter; it stops at the top
  // saturating keeps a long pulse from wrapping back under the limit
  function [7:0] cnt_next;
    input [7:0] cnt;
    begin
      cnt_next = (cnt == 8'hff) ? cnt : cnt + 8'h01;
    end
  endfunction

  wire [2:0] over = {mag7(accel_z) > {1'b0, thr_z_q},
                     mag7(accel_y) > {1'b0, thr_y_q},
                     mag7(accel_x) > {1'b0, thr_x_q}};
  wire [2:0] sign = {accel_z[DATA_W-1], accel_y[DATA_W-1],
                     accel_x[DATA_W-1]};
  wire       any_over = |over;

  // axes of this cycle's event that pass the enables, and whether any
  // do; a disabled axis or type never reaches the source register
  wire [2:0] ev_axes = qual_axes(ev_double, ev_axis, sgl_en, dbl_en);
  wire       ev_hit  = (ev_single || ev_double) && (|ev_axes);

  // =========================================================
  // register writes; source is read only and ignores writes
  always @(posedge clk) begin
    if (!rst_n) begin
      config_q     <= `CONFIG_RESET;
      thr_x_q      <= `THRESHOLD_RESET;
      thr_y_q      <= `THRESHOLD_RESET;
      thr_z_q      <= `THRESHOLD_RESET;
      time_limit_q <= `COUNT_RESET;
      latency_q    <= `COUNT_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        `TAP_CONFIG_ADDR:      config_q     <= reg_wdata;
        `TAP_THRESHOLD_X_ADDR: thr_x_q      <= reg_wdata[6:0];
        `TAP_THRESHOLD_Y_ADDR: thr_y_q      <= reg_wdata[6:0];
        `TAP_THRESHOLD_Z_ADDR: thr_z_q      <= reg_wdata[6:0];
        // time limit and latency count samples, not clocks
        `TAP_TIME_LIMIT_ADDR:  time_limit_q <= reg_wdata;
        `TAP_LATENCY_ADDR:     latency_q    <= reg_wdata;
        default:               config_q     <= config_q;
      endcase
    end
  end

  // =========================================================
  // tap detector: above-threshold width check, then latency window
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      width_cnt_q   <= 8'h00;
      lat_cnt_q     <= 8'h00;
      axis_q        <= 3'b000;
      pol_q         <= 3'b000;
      first_seen_q  <= 1'b0;
      single_pend_q <= 1'b0;
      lat_over_q    <= 1'b0;
      ev_single     <= 1'b0;
      ev_double     <= 1'b0;
      ev_axis       <= 3'b000;
      ev_pol        <= 3'b000;
    end else begin
      ev_single <= 1'b0;
      ev_double <= 1'b0;
      if (sample_en) begin
        case (state_q)
          ST_IDLE: begin
            single_pend_q <= 1'b0;
            if (any_over) begin
              state_q     <= ST_ABOVE;
              width_cnt_q <= 8'h00;
              axis_q      <= over;
              pol_q       <= sign & over;
            end else if (single_pend_q) begin
              // no second pulse right after latency: the first tap was
              // a single, so the next pulse starts afresh
              first_seen_q <= 1'b0;
            end
          end
          ST_ABOVE: begin
            if (!any_over) begin
              // pulse ended inside the limit: a valid tap
              state_q   <= ST_LAT;
              lat_cnt_q <= 8'h00;
              if (first_seen_q) begin
                ev_double    <= 1'b1;
                ev_axis      <= axis_q;
                ev_pol       <= pol_q;
                first_seen_q <= 1'b0;
              end else begin
                ev_single    <= 1'b1;
                ev_axis      <= axis_q;
                ev_pol       <= pol_q;
                first_seen_q <= 1'b1;
              end
            end else if (cnt_done(width_cnt_q, time_limit_q)) begin
              state_q      <= ST_IDLE;
              first_seen_q <= 1'b0;
            end else begin
              width_cnt_q <= cnt_next(width_cnt_q);
            end
          end
          ST_LAT: begin
            if (cnt_done(lat_cnt_q, latency_q)) begin
              state_q       <= ST_IDLE;
              lat_over_q    <= 1'b0;
              single_pend_q <= first_seen_q;
            end else begin
              lat_cnt_q <= cnt_next(lat_cnt_q);
              // taps inside latency are ignored; a pulse that both starts
              // and ends in it cancels a pending double when abort is set
              if (any_over) begin
                lat_over_q <= 1'b1;
              end else if (lat_over_q) begin
                lat_over_q <= 1'b0;
                if (abort_en)
                  first_seen_q <= 1'b0;
                // abort clear keeps the first tap pending
                else
                  first_seen_q <= first_seen_q;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // =========================================================
  // source flag next value: read clears, new event wins, latch freezes
  always @* begin
    source_d = src_rd ? `SOURCE_RESET : source_q;
    if (ev_hit) begin
      // a latched, active source keeps its status bits; a read in the
      // same cycle has just cleared it, so the new event lands in full
      if (!(latch_en && source_q[`SRC_ACTIVE_BIT] && !src_rd)) begin
        source_d[6:4]             = ev_axes;
        source_d[`SRC_DOUBLE_BIT] = ev_double;
        source_d[2:0]             = ev_pol & ev_axes;
      end
      source_d[`SRC_ACTIVE_BIT] = 1'b1;
    end else if (!latch_en) begin
      // without the latch only the event of this cycle shows
      source_d = `SOURCE_RESET;
    end
  end

  // =========================================================
  // source register, interrupt request and read data
  always @(posedge clk) begin
    if (!rst_n) begin
      source_q  <= `SOURCE_RESET;
      tap_irq   <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      source_q <= source_d;
      tap_irq  <= source_d[`SRC_ACTIVE_BIT];
      // read data stands until the next read strobe
      if (reg_rd) begin
        case (reg_addr)
          `TAP_CONFIG_ADDR:      reg_rdata <= config_q;
          `TAP_SOURCE_ADDR:      reg_rdata <= source_q;
          `TAP_THRESHOLD_X_ADDR: reg_rdata <= {1'b0, thr_x_q};
          `TAP_THRESHOLD_Y_ADDR: reg_rdata <= {1'b0, thr_y_q};
          `TAP_THRESHOLD_Z_ADDR: reg_rdata <= {1'b0, thr_z_q};
          `TAP_TIME_LIMIT_ADDR:  reg_rdata <= time_limit_q;
          `TAP_LATENCY_ADDR:     reg_rdata <= latency_q;
          default:               reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ### verif/tap_event_regs_props.sv
// tap_event_regs_props.sv: port checks of the tap register block
// assumes: bound to tap_event_regs, one clock, sync reset
`timescale 1ns/1ps
// ====
// checker
module tap_event_regs_props (
  input wire       clk,
  input wire       rst_n,
  input wire       sample_en,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire       tap_irq
);
  reg [7:0] cfg_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of the configuration register
  always @(posedge clk) begin
    if (!rst_n)
      cfg_q <= 8'h00;
    else if (reg_wr && reg_addr == 8'h21)
      cfg_q <= reg_wdata;
  end
  sequence src_read;
    reg_rd && reg_addr == 8'h22;
  endsequence
  sequence quiet;
    !sample_en && !$past(sample_en) && !$past(sample_en, 2);
  endsequence
  AST_RESET: assert property (disable iff (1'b0) !rst_n |=>
    reg_rdata == 8'h00 && !tap_irq) else $error("no reset clear");
  AST_CFG: assert property (reg_rd && reg_addr == 8'h21 |=>
    reg_rdata == cfg_q) else $error("config readback off");
  AST_THR: assert property (reg_rd && reg_addr inside {[8'h23:8'h25]}
    |=> !reg_rdata[7]) else $error("threshold top bit set");
  AST_MAP: assert property (reg_rd && !(reg_addr inside {[8'h21:8'h27]})
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_STAND: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_ACTIVE: assert property (src_read |=> reg_rdata[7] == $past(tap_irq))
    else $error("active flag differs from irq");
  AST_EMPTY: assert property (src_read ##0 !tap_irq |=> reg_rdata == 8'h00)
    else $error("flags without active");
  AST_CLEAR: assert property (src_read ##0 quiet ##0 !$past(sample_en, 3)
    |=> !tap_irq) else $error("irq kept after read");
  AST_HOLD: assert property (tap_irq && cfg_q[6] && !src_read |=>
    tap_irq) else $error("latched irq lost");
endmodule
bind tap_event_regs tap_event_regs_props u_props (.clk(clk), .rst_n(rst_n),
  .sample_en(sample_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .tap_irq(tap_irq));

// ### verif/tap_host.sv
// tap_host.sv: host model issuing register strobes
// assumes: strobes taken on the rising clk edge
`timescale 1ns/1ps
// ====
// host
module tap_host (
  input  wire       clk,
  output reg        reg_wr = 1'b0,
  output reg        reg_rd = 1'b0,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00
);
  // one write strobe; released fields show inverted values
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
    end
  endtask
  // one read strobe
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
    end
  endtask
endmodule

// ### verif/testbench.sv
// testbench.sv: self-checking bench of the tap register block
// assumes: host model drives registers, bench drives samples
`timescale 1ns/1ps
// ====
// bench
module testbench;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        sample_en = 1'b0;
  reg  [9:0] ax = 10'h000;
  reg  [9:0] ay = 10'h000;
  reg  [9:0] az = 10'h000;
  reg        rd_seen = 1'b0;
  reg  [7:0] exp_q[$];
  wire       reg_wr;
  wire       reg_rd;
  wire [7:0] reg_addr;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire       tap_irq;
  integer    failures = 0;
  integer    check_count = 0;
  integer    irq_rises = 0;
  reg        irq_prev = 1'b0;
  always #5 clk = ~clk;
  tap_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  tap_event_regs u_tap_event_regs (.clk(clk), .rst_n(rst_n),
    .sample_en(sample_en), .accel_x(ax), .accel_y(ay), .accel_z(az),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tap_irq(tap_irq));
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // compare read data one cycle after each read strobe
  always @(posedge clk) begin
    if (rd_seen)
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  // count rising edges of the interrupt request
  always @(posedge clk) begin
    if (tap_irq === 1'b1 && irq_prev === 1'b0)
      irq_rises <= irq_rises + 1;
    irq_prev <= tap_irq;
  end
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back(e);
      u_host.rd(a);
    end
  endtask
  // one sample; y and z stay below their thresholds
  task smp(input [9:0] x);
    begin
      @(posedge clk);
      sample_en <= 1'b1;
      ax <= x;
      ay <= 10'($urandom % 64);
      az <= 10'($urandom % 64);
      @(posedge clk);
      sample_en <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  // one tap sample followed by quiet samples
  task tap(input [9:0] x);
    begin
      smp(x);
      repeat (8) smp(10'($urandom % 16));
      #1;
    end
  endtask
  // six samples, a set bit of m meaning a pulse of value x, then quiet
  task pat(input [5:0] m, input [9:0] x);
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1)
        smp(m[i] ? x : 10'($urandom % 16));
      repeat (8) smp(10'($urandom % 16));
    end
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    final_report;
  end
  initial begin
    void'($urandom(54));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h21, 8'h00);
    rd(8'h22, 8'h00);
    rd(8'h23, 8'h00);
    u_host.wr(8'h23, 8'hff);
    rd(8'h23, 8'h7f);
    u_host.wr(8'h22, 8'hff);
    rd(8'h22, 8'h00);
    rd(8'h30, 8'h00);
    u_host.wr(8'h23, 8'h10);
    u_host.wr(8'h24, 8'h7f);
    u_host.wr(8'h25, 8'h7f);
    u_host.wr(8'h26, 8'h04);
    u_host.wr(8'h27, 8'h02);
    u_host.wr(8'h21, 8'h41);
    rd(8'h21, 8'h41);
    rd(8'h24, 8'h7f);
    tap(10'h1f0);
    check("tap_irq", {7'h00, tap_irq}, 8'h01);
    rd(8'h22, 8'h90);
    rd(8'h22, 8'h00);
    #1 check("tap_irq", {7'h00, tap_irq}, 8'h00);
    tap(10'h210);
    rd(8'h22, 8'h91);
    u_host.wr(8'h21, 8'h42);
    tap(10'h1f0);
    rd(8'h22, 8'h00);
    u_host.wr(8'h21, 8'h62);
    pat(6'h25, 10'h1f0);
    rd(8'h22, 8'h98);
    u_host.wr(8'h21, 8'he2);
    pat(6'h25, 10'h1f0);
    rd(8'h22, 8'h00);
    u_host.wr(8'h21, 8'h43);
    tap(10'h1f0);
    tap(10'h210);
    rd(8'h22, 8'h90);
    u_host.wr(8'h21, 8'h01);
    tap(10'h1f0);
    rd(8'h22, 8'h00);
    check("irq_rises", irq_rises[7:0], 8'h05);
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule
